/* design/ife_bank.sv */
// Interrupt flag status and enable bank behind an Avalon-MM slave
//
// Notes on behaviour
// - Flag reads one after its request
// - Enable one passes the request on
// - Unimplemented bits always read zero
// - Change notify flag at bit 3
// - Capture 8 flag at bit 7
// - Capture 7 flag at bit 6
// - Third flags: 15, 10, 9 only
// - Fourth flags: 10, 9, 1 only
// - Enables0: ADC 13, UART tx 12, SPI fault 9
// - UART rx enable at bit 11
// - SPI event enable at bit 10
// - Timer 3 enable at bit 8
// - Capture 1 enable at bit 1
// - External irq 0 enable at bit 0
// - Cleared enables1 bit blocks a set flags1 flag; flags3 and flags4 pass ungated
// - Enables1 matches flags1 bit layout
`timescale 1ns/1ps
`include "ife_defs.svh"

module ife_bank (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // Avalon-MM slave
  input  wire ife_pkg::ife_avmm_req_t avs_req,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  output logic [1:0]                 avs_response,
  // Peripheral request pulses or levels, same clock
  input  wire ife_pkg::ife_src_t     src_req,
  input  wire logic [13:0]           enables0_req,
  // Requests towards arbitration, flags1 and enables0 gated by their enables
  output logic [15:0]                pend_flags1,
  output logic [15:0]                pend_flags3,
  output logic [15:0]                pend_flags4,
  output logic [15:0]                pend_enables0,
  // Summary interrupt
  output logic                       irq
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [15:0]             irq_flags_1;
  logic [15:0]             irq_flags_3;
  logic [15:0]             irq_flags_4;
  logic [15:0]             irq_enables_0;
  logic [15:0]             irq_enables_1;
  logic [15:0]             irq_stat;
  logic [15:0]             irq_mask;
  ife_pkg::ife_bus_state_t state;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Accept on the first cycle, answer one cycle later
  wire        req_any   = avs_req.read | avs_req.write;
  wire        take      = req_any & (state == ife_pkg::IFE_IDLE);
  wire        wr        = take & avs_req.write;
  wire [15:0] wmask     = {{8{avs_req.byteenable[1]}}, {8{avs_req.byteenable[0]}}};
  wire [15:0] wdata     = avs_req.writedata[15:0];
  wire [3:0]  widx      = avs_req.address;
  wire        hit_f1    = widx == `IFE_OFF_FLAGS1;
  wire        hit_f3    = widx == `IFE_OFF_FLAGS3;
  wire        hit_f4    = widx == `IFE_OFF_FLAGS4;
  wire        hit_e0    = widx == `IFE_OFF_ENABLES0;
  wire        hit_e1    = widx == `IFE_OFF_ENABLES1;
  wire        hit_st    = widx == `IFE_OFF_IRQ_STAT;
  wire        hit_mk    = widx == `IFE_OFF_IRQ_MASK;
  wire        mapped    = hit_f1 | hit_f3 | hit_f4 | hit_e0 | hit_e1 | hit_st | hit_mk;

  // ****************************************************************
  // Flag update
  // ****************************************************************
  // Request sets win over a software clear in the same cycle
  function automatic logic [15:0] flag_next(input logic [15:0] cur,
                                            input logic [15:0] set,
                                            input logic        hit,
                                            input logic [15:0] impl);
    logic [15:0] v;
    v = cur;
    if (hit) begin
      v = (cur & ~wmask) | (wdata & wmask);
    end
    flag_next = (v | set) & impl;
  endfunction

  // sticky flags, software set and clear
  wire [15:0] next_flags_1   = flag_next(irq_flags_1, src_req.flags1, wr & hit_f1,
                                         `IFE_MASK_FLAGS1);
  wire [15:0] next_flags_3   = flag_next(irq_flags_3, src_req.flags3, wr & hit_f3,
                                         `IFE_MASK_FLAGS3);
  wire [15:0] next_flags_4   = flag_next(irq_flags_4, src_req.flags4, wr & hit_f4,
                                         `IFE_MASK_FLAGS4);
  // Enables0 sources have no flags here; their requests arrive in bit order
  wire [15:0] src0           = {2'h0, enables0_req} & `IFE_MASK_ENABLES0;

  // Events for the summary interrupt: a new request per register
  wire [3:0]  evt = {|(src0 & irq_enables_0 & ~pend_enables0),
                     |(src_req.flags4 & ~irq_flags_4 & `IFE_MASK_FLAGS4),
                     |(src_req.flags3 & ~irq_flags_3 & `IFE_MASK_FLAGS3),
                     |(src_req.flags1 & ~irq_flags_1 & `IFE_MASK_FLAGS1)};
  wire [15:0] stat_clr       = (wr & hit_st) ? (wdata & wmask) : `IFE_RESET_VALUE;
  wire [15:0] next_stat      = ((irq_stat & ~stat_clr) | {12'h000, evt}) & `IFE_MASK_IRQ;

  wire [15:0] rd16 = hit_f1 ? irq_flags_1 :
                     hit_f3 ? irq_flags_3 :
                     hit_f4 ? irq_flags_4 :
                     hit_e0 ? irq_enables_0 :
                     hit_e1 ? irq_enables_1 :
                     hit_st ? irq_stat :
                     hit_mk ? irq_mask : `IFE_RESET_VALUE;

  // ****************************************************************
  // Registers
  // ****************************************************************
  // everything clears at reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_flags_1   <= `IFE_RESET_VALUE;
      irq_flags_3   <= `IFE_RESET_VALUE;
      irq_flags_4   <= `IFE_RESET_VALUE;
      irq_stat      <= `IFE_RESET_VALUE;
    end else begin
      irq_flags_1   <= next_flags_1;
      irq_flags_3   <= next_flags_3;
      irq_flags_4   <= next_flags_4;
      irq_stat      <= next_stat;
    end
  end

  // Software-owned enables and mask
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_enables_0 <= `IFE_RESET_VALUE;
      irq_enables_1 <= `IFE_RESET_VALUE;
      irq_mask      <= `IFE_RESET_VALUE;
    end else if (wr) begin
      // enables0 layout, bits 15-14 and 4 held zero
      if (hit_e0) begin
        irq_enables_0 <= ((irq_enables_0 & ~wmask) | (wdata & wmask)) & `IFE_MASK_ENABLES0;
      end
      if (hit_e1) begin
        irq_enables_1 <= ((irq_enables_1 & ~wmask) | (wdata & wmask)) & `IFE_MASK_FLAGS1;
      end
      if (hit_mk) begin
        irq_mask      <= ((irq_mask & ~wmask) | (wdata & wmask)) & `IFE_MASK_IRQ;
      end
    end
  end

  // ****************************************************************
  // Pending requests, enabled for flags1 and enables0
  // ****************************************************************
  // pass flags1 and enables0 requests only when enabled; flags3 and flags4 pass ungated
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_flags1   <= `IFE_RESET_VALUE;
      pend_flags3   <= `IFE_RESET_VALUE;
      pend_flags4   <= `IFE_RESET_VALUE;
      pend_enables0 <= `IFE_RESET_VALUE;
      irq           <= 1'b0;
    end else begin
      pend_flags1   <= next_flags_1 & irq_enables_1;
      pend_flags3   <= next_flags_3;
      pend_flags4   <= next_flags_4;
      pend_enables0 <= src0 & irq_enables_0;
      irq           <= |(next_stat & irq_mask);
    end
  end

  // ****************************************************************
  // Bus answer
  // ****************************************************************
  // Waitrequest high until the answer cycle; unmapped reads zero, slave error
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state           <= ife_pkg::IFE_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      avs_response    <= 2'b00;
    end else if (take) begin
      state           <= ife_pkg::IFE_ACK;
      avs_waitrequest <= 1'b0;
      avs_readdata    <= {16'h0000, avs_req.read ? rd16 : `IFE_RESET_VALUE};
      avs_response    <= mapped ? 2'b00 : 2'b10;
    end else begin
      state           <= ife_pkg::IFE_IDLE;
      avs_waitrequest <= 1'b1;
      avs_response    <= 2'b00;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // reserved bits of flags1 stay zero
  property p_flags1_reserved;
    @(posedge ref_clk) disable iff (!rst_n)
      (irq_flags_1 & ~`IFE_MASK_FLAGS1) == 16'h0000;
  endproperty
  a_flags1_reserved: assert property (p_flags1_reserved) else $error("flags1 reserved set");

  property p_flag_sets;
    @(posedge ref_clk) disable iff (!rst_n)
      src_req.flags1[`IFE_BIT_CHANGE_NOTIFY] |=> irq_flags_1[`IFE_BIT_CHANGE_NOTIFY];
  endproperty
  a_flag_sets: assert property (p_flag_sets) else $error("change flag not set");

  property p_cap8;
    @(posedge ref_clk) disable iff (!rst_n)
      src_req.flags1[`IFE_BIT_CAPTURE8] |=> irq_flags_1[`IFE_BIT_CAPTURE8];
  endproperty
  a_cap8: assert property (p_cap8) else $error("capture8 flag not set");

  property p_flags3_layout;
    @(posedge ref_clk) disable iff (!rst_n)
      (irq_flags_3 & ~`IFE_MASK_FLAGS3) == 16'h0000;
  endproperty
  a_flags3_layout: assert property (p_flags3_layout) else $error("flags3 bad bit");

  property p_flags4_layout;
    @(posedge ref_clk) disable iff (!rst_n)
      src_req.flags4[`IFE_BIT_UART_ERROR] |=> irq_flags_4[`IFE_BIT_UART_ERROR];
  endproperty
  a_flags4_layout: assert property (p_flags4_layout) else $error("uart error flag lost");

  property p_sticky;
    @(posedge ref_clk) disable iff (!rst_n)
      (irq_flags_3[`IFE_BIT_PWM1_FAULT] && !(wr && hit_f3))
        |=> irq_flags_3[`IFE_BIT_PWM1_FAULT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without write");

  property p_gate;
    @(posedge ref_clk) disable iff (!rst_n)
      !irq_enables_1[`IFE_BIT_EXT_IRQ2] |=> !pend_flags1[`IFE_BIT_EXT_IRQ2] || $past(wr);
  endproperty
  a_gate: assert property (p_gate) else $error("disabled request passed");

  property p_en0_reserved;
    @(posedge ref_clk) disable iff (!rst_n)
      (irq_enables_0 & ~`IFE_MASK_ENABLES0) == 16'h0000;
  endproperty
  a_en0_reserved: assert property (p_en0_reserved) else $error("enables0 reserved set");

  property p_answer;
    @(posedge ref_clk) disable iff (!rst_n)
      (req_any && state == ife_pkg::IFE_IDLE) |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer timing");

  property p_cap7;
    @(posedge ref_clk) disable iff (!rst_n)
      src_req.flags1[`IFE_BIT_CAPTURE7] |=> irq_flags_1[`IFE_BIT_CAPTURE7];
  endproperty
  a_cap7: assert property (p_cap7) else $error("capture7 flag not set");

  property p_ext_irq2;
    @(posedge ref_clk) disable iff (!rst_n)
      src_req.flags1[`IFE_BIT_EXT_IRQ2] |=> irq_flags_1[`IFE_BIT_EXT_IRQ2];
  endproperty
  a_ext_irq2: assert property (p_ext_irq2) else $error("ext irq2 flag not set");

  property p_i2c_master;
    @(posedge ref_clk) disable iff (!rst_n)
      src_req.flags1[`IFE_BIT_I2C_MASTER] |=> irq_flags_1[`IFE_BIT_I2C_MASTER];
  endproperty
  a_i2c_master: assert property (p_i2c_master) else $error("i2c flag not set");

  property p_pwm1_error;
    @(posedge ref_clk) disable iff (!rst_n)
      src_req.flags3[`IFE_BIT_PWM1_ERROR] |=> irq_flags_3[`IFE_BIT_PWM1_ERROR];
  endproperty
  a_pwm1_error: assert property (p_pwm1_error) else $error("pwm1 error flag lost");

  property p_flags4_reserved;
    @(posedge ref_clk) disable iff (!rst_n)
      (irq_flags_4 & ~`IFE_MASK_FLAGS4) == 16'h0000;
  endproperty
  a_flags4_reserved: assert property (p_flags4_reserved) else $error("flags4 bad bit");

  property p_flag_quiet;
    @(posedge ref_clk) disable iff (!rst_n)
      (!irq_flags_3[`IFE_BIT_POS_DECODER] && !src_req.flags3[`IFE_BIT_POS_DECODER]
        && !(wr && hit_f3)) |=> !irq_flags_3[`IFE_BIT_POS_DECODER];
  endproperty
  a_flag_quiet: assert property (p_flag_quiet) else $error("flag set unasked");

  property p_sw_set;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && hit_f4 && avs_req.byteenable[1] && wdata[`IFE_BIT_PWM2_FAULT])
        |=> irq_flags_4[`IFE_BIT_PWM2_FAULT];
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("software set lost");

  property p_uart_rx_en;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && hit_e0 && avs_req.byteenable[1])
        |=> irq_enables_0[`IFE_BIT_UART_RX] == $past(wdata[`IFE_BIT_UART_RX]);
  endproperty
  a_uart_rx_en: assert property (p_uart_rx_en) else $error("uart rx enable wrong");

  property p_spi_event_en;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && hit_e0 && avs_req.byteenable[1])
        |=> irq_enables_0[`IFE_BIT_SPI_EVENT] == $past(wdata[`IFE_BIT_SPI_EVENT]);
  endproperty
  a_spi_event_en: assert property (p_spi_event_en) else $error("spi enable wrong");

  property p_timer3_en;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && hit_e0 && avs_req.byteenable[1])
        |=> irq_enables_0[`IFE_BIT_TIMER3] == $past(wdata[`IFE_BIT_TIMER3]);
  endproperty
  a_timer3_en: assert property (p_timer3_en) else $error("timer3 enable wrong");

  property p_capture1_en;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && hit_e0 && avs_req.byteenable[0])
        |=> irq_enables_0[`IFE_BIT_CAPTURE1] == $past(wdata[`IFE_BIT_CAPTURE1]);
  endproperty
  a_capture1_en: assert property (p_capture1_en) else $error("capture1 enable wrong");

  property p_ext_irq0_en;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && hit_e0 && avs_req.byteenable[0])
        |=> irq_enables_0[`IFE_BIT_EXT_IRQ0] == $past(wdata[`IFE_BIT_EXT_IRQ0]);
  endproperty
  a_ext_irq0_en: assert property (p_ext_irq0_en) else $error("ext irq0 enable wrong");

  property p_en0_pass;
    @(posedge ref_clk) disable iff (!rst_n)
      (src0[`IFE_BIT_ADC_DONE] && irq_enables_0[`IFE_BIT_ADC_DONE])
        |=> pend_enables0[`IFE_BIT_ADC_DONE];
  endproperty
  a_en0_pass: assert property (p_en0_pass) else $error("enabled request dropped");

  property p_en0_block;
    @(posedge ref_clk) disable iff (!rst_n)
      !irq_enables_0[`IFE_BIT_UART_TX] |=> !pend_enables0[`IFE_BIT_UART_TX];
  endproperty
  a_en0_block: assert property (p_en0_block) else $error("disabled enables0 passed");

  property p_en1_reserved;
    @(posedge ref_clk) disable iff (!rst_n)
      (irq_enables_1 & ~`IFE_MASK_FLAGS1) == 16'h0000;
  endproperty
  a_en1_reserved: assert property (p_en1_reserved) else $error("enables1 reserved set");

  property p_reset_clear;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(rst_n) |-> (irq_flags_1 | irq_flags_3 | irq_flags_4 | irq_enables_0) == 16'h0000;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("state not clear at reset");

endmodule

/* design/ife_defs.svh */
// Register offsets, field positions and masks of the interrupt flag and enable bank
`ifndef IFE_DEFS_SVH
`define IFE_DEFS_SVH

// ****************************************************************
// Register word offsets
// ****************************************************************
`define IFE_OFF_FLAGS1   4'h0
`define IFE_OFF_FLAGS3   4'h1
`define IFE_OFF_FLAGS4   4'h2
`define IFE_OFF_ENABLES0 4'h3
`define IFE_OFF_ENABLES1 4'h4
`define IFE_OFF_IRQ_STAT 4'h5
`define IFE_OFF_IRQ_MASK 4'h6

// ****************************************************************
// Implemented bit masks
// ****************************************************************
`define IFE_MASK_FLAGS1   16'h20db
`define IFE_MASK_FLAGS3   16'h8600
`define IFE_MASK_FLAGS4   16'h0602
`define IFE_MASK_ENABLES0 16'h3fef
`define IFE_MASK_IRQ      16'h000f
`define IFE_RESET_VALUE   16'h0000

// ****************************************************************
// Field positions
// ****************************************************************
`define IFE_BIT_EXT_IRQ2       13
`define IFE_BIT_CAPTURE8        7
`define IFE_BIT_CAPTURE7        6
`define IFE_BIT_EXT_IRQ1        4
`define IFE_BIT_CHANGE_NOTIFY   3
`define IFE_BIT_I2C_MASTER      1
`define IFE_BIT_I2C_SLAVE       0
`define IFE_BIT_PWM1_FAULT     15
`define IFE_BIT_POS_DECODER    10
`define IFE_BIT_PWM1_ERROR      9
`define IFE_BIT_PWM2_FAULT     10
`define IFE_BIT_PWM2_ERROR      9
`define IFE_BIT_UART_ERROR      1
`define IFE_BIT_ADC_DONE       13
`define IFE_BIT_UART_TX        12
`define IFE_BIT_UART_RX        11
`define IFE_BIT_SPI_EVENT      10
`define IFE_BIT_SPI_FAULT       9
`define IFE_BIT_TIMER3          8
`define IFE_BIT_CAPTURE1        1
`define IFE_BIT_EXT_IRQ0        0

`endif

/* design/ife_pkg.sv */
// Types shared by the interrupt flag and enable bank
package ife_pkg;

  // Avalon-MM request carried as one bundle
  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } ife_avmm_req_t;

  // Request lines from the peripherals, one per flag register
  typedef struct packed {
    logic [15:0] flags1;
    logic [15:0] flags3;
    logic [15:0] flags4;
  } ife_src_t;

  // Bus slave states, Gray coded
  typedef enum logic [1:0] {
    IFE_IDLE = 2'b00,
    IFE_ACK  = 2'b01
  } ife_bus_state_t;

endpackage

/* tb/ife_src_model.sv */
// Peripheral request source model facing the flag and enable bank
`timescale 1ns/1ps

module ife_src_model (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  // Commands from the bench
  input  wire logic               fire,
  input  wire logic [1:0]         sel,
  input  wire logic [15:0]        bits,
  // Request lines
  output ife_pkg::ife_src_t       src_req,
  output logic      [13:0]        enables0_req
);
  // Flag sources pulse one cycle, enables0 sources hold a level
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_req      <= '0;
      enables0_req <= 14'h0000;
    end else begin
      src_req <= '0;
      if (fire && sel == 2'h0) src_req.flags1 <= bits;
      if (fire && sel == 2'h1) src_req.flags3 <= bits;
      if (fire && sel == 2'h2) src_req.flags4 <= bits;
      if (fire && sel == 2'h3) enables0_req <= bits[13:0];
    end
  end
endmodule

/* tb/ife_bank_tb.sv */
// Self-checking bench for the interrupt flag and enable bank
`timescale 1ns/1ps
`include "ife_defs.svh"

module ife_bank_tb;
  logic                   ref_clk;
  logic                   rst_n;
  logic                   fire;
  logic [1:0]             sel;
  logic [15:0]            bits;
  ife_pkg::ife_avmm_req_t req;
  ife_pkg::ife_src_t      src;
  logic [13:0]            en0_req;
  logic [31:0]            rdata;
  logic [31:0]            q;
  logic                   wreq;
  logic [1:0]             resp;
  logic [1:0]             rq;
  logic [15:0]            pf1;
  logic [15:0]            pf3;
  logic [15:0]            pf4;
  logic [15:0]            pe0;
  logic                   irq;
  logic [15:0]            masks [5];
  logic [15:0]            ex;
  int                     miscompares;
  int                     n_checks;

  // Clock at 50 MHz
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  ife_src_model SRC (.ref_clk(ref_clk), .rst_n(rst_n), .fire(fire), .sel(sel),
    .bits(bits), .src_req(src), .enables0_req(en0_req));

  ife_bank DUT (.ref_clk(ref_clk), .rst_n(rst_n), .avs_req(req), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .avs_response(resp), .src_req(src), .enables0_req(en0_req),
    .pend_flags1(pf1), .pend_flags3(pf3), .pend_flags4(pf4), .pend_enables0(pe0),
    .irq(irq));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task summarize;
    $display("counts: %0d checks, %0d mismatches", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Avalon request held until waitrequest is sampled low at a rising edge
  task bus(input logic w, input int a, input logic [15:0] d);
    int n;
    @(posedge ref_clk);
    req.address   <= 4'(a);
    req.read      <= !w;
    req.write     <= w;
    req.writedata <= {16'h0000, d};
    n = 0;
    // Values read here are those sampled by the edge itself
    do begin
      @(posedge ref_clk);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    if (wreq !== 1'b0) begin
      miscompares++;
      summarize();
    end else begin
      q         = rdata;
      rq        = resp;
      req.read  <= 1'b0;
      req.write <= 1'b0;
    end
  endtask

  task wr(input int a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask

  task rd(input int a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(q, {16'h0000, e});
  endtask

  // One command to the source model, then time to land in the flags
  task pulse(input logic [1:0] s, input logic [15:0] b);
    @(posedge ref_clk);
    fire <= 1'b1;
    sel  <= s;
    bits <= b;
    @(posedge ref_clk);
    fire <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    fire = 1'b0;
    sel = 2'h0;
    bits = 16'h0000;
    req = '0;
    req.byteenable = 4'h3;
    miscompares = 0;
    n_checks = 0;
    masks = '{`IFE_MASK_FLAGS1, `IFE_MASK_FLAGS3, `IFE_MASK_FLAGS4, `IFE_MASK_ENABLES0,
              `IFE_MASK_FLAGS1};
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 7; a++) rd(a, 16'h0000);
    chk({pf1, pf3}, 32'h0000_0000);
    chk({pf4, pe0}, 32'h0000_0000);
    $display("test reset done");
    // Ones written land only on implemented bits; zero clears
    for (int a = 0; a < 5; a++) begin
      wr(a, 16'hffff);
      rd(a, masks[a]);
      wr(a, 16'h0000);
      rd(a, 16'h0000);
    end
    $display("test access done");
    // Every flag source line, implemented or not, pulsed alone
    for (int s = 0; s < 3; s++) begin
      for (int b = 0; b < 16; b++) begin
        pulse(2'(s), 16'h0001 << b);
        rd(s, masks[s] & (16'h0001 << b));
        ex = masks[s] & (16'h0001 << b);
        chk({pf3, pf4}, {(s == 1) ? ex : 16'h0000, (s == 2) ? ex : 16'h0000});
        wr(s, 16'h0000);
      end
    end
    $display("test sources done");
    // Each enables0 bit passes only its own request
    pulse(2'h3, 16'h3fff);
    for (int b = 0; b < 16; b++) begin
      wr(3, 16'h0001 << b);
      repeat (3) @(posedge ref_clk);
      chk({16'h0000, pe0}, {16'h0000, masks[3] & (16'h0001 << b)});
    end
    wr(3, 16'h0000);
    repeat (3) @(posedge ref_clk);
    chk({16'h0000, pe0}, 32'h0000_0000);
    // Enables1 gating of a set flags1 bit
    pulse(2'h0, 16'h2000);
    repeat (3) @(posedge ref_clk);
    chk({16'h0000, pf1}, 32'h0000_0000);
    wr(4, 16'h2000);
    repeat (3) @(posedge ref_clk);
    chk({16'h0000, pf1}, 32'h0000_2000);
    $display("test enables done");
    // Summary interrupt raised, cleared, then masked
    wr(6, 16'h0001);
    wr(5, 16'h000f);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    pulse(2'h0, 16'h0008);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    rd(5, 16'h0001);
    wr(5, 16'h0001);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    wr(6, 16'h0000);
    pulse(2'h1, 16'h0200);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    rd(5, 16'h0002);
    chk({30'h0, rq}, 32'h0);
    $display("test interrupt done");
    // Unmapped index answers with slave error
    wr(7, 16'hffff);
    rd(7, 16'h0000);
    chk({30'h0, rq}, 32'h2);
    $display("test unmapped done");
    summarize();
  end
endmodule
